//--- rtl/wdrs_pkg.sv
/*
 * wdrs_pkg: constants shared by the watchdog and reset-source block:
 * register offsets, field positions, reset values, key bytes and timing counts.
 * assumes a byte-wide register port and a 100 MHz system clock.
 */
`default_nettype none

package wdrs_pkg;

    // ************************************************************
    // register map (byte offsets on the plain register port)
    // ************************************************************
    localparam int ADDR_W = 3;
    localparam logic [ADDR_W-1:0] OFS_CAUSE = 3'h0;   // reset_cause_register, writes are keys
    localparam logic [ADDR_W-1:0] OFS_OPT1 = 3'h1;    // system_options_first, write once
    localparam logic [ADDR_W-1:0] OFS_OPT2 = 3'h2;    // system_options_second, write once
    localparam logic [ADDR_W-1:0] OFS_STATUS = 3'h3;  // watchdog state, read only

    // ************************************************************
    // service keys
    // ************************************************************
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;

    // ************************************************************
    // option fields and their reset values
    // ************************************************************
    localparam int OPT1_TMO_LSB = 0;        // watchdog_timeout_select[1:0]
    localparam int OPT2_CLKSEL_BIT = 0;     // watchdog_clock_select, 1 = 1 kHz source
    localparam int OPT2_WINDOW_BIT = 1;     // watchdog_window_enable
    localparam logic [1:0] TMO_OFF = 2'h0;
    localparam logic [1:0] TMO_RST = 2'h3;  // longest timeout
    localparam logic CLKSEL_RST = 1'b1;
    localparam logic WINDOW_RST = 1'b0;

    // ************************************************************
    // reset cause bits, bit 0 reads as zero
    // ************************************************************
    localparam int CAUSE_POR = 7;
    localparam int CAUSE_PIN = 6;
    localparam int CAUSE_WDOG = 5;
    localparam int CAUSE_ILLEGAL_OPCODE_RESET = 4;
    localparam int CAUSE_ILLEGAL_ADDRESS_RESET = 3;
    localparam int CAUSE_CLKLOSS = 2;
    localparam int CAUSE_LOWV = 1;
    localparam logic [7:0] CAUSE_POR_VAL = 8'h80;

    // ************************************************************
    // status register bits
    // ************************************************************
    localparam int STAT_OPT1_LOCK = 0;
    localparam int STAT_OPT2_LOCK = 1;
    localparam int STAT_KEY_ARMED = 2;
    localparam int STAT_WIN_OPEN = 3;

    // ************************************************************
    // cpu-facing reset values
    // ************************************************************
    localparam logic [15:0] RESET_VECTOR_ADDR = 16'hfffe;
    localparam logic [15:0] STACK_PTR_RST = 16'h00ff;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int RESET_HOLD_NS = 160;
    localparam int RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_W = 8;

    // key sequence tracker
    typedef enum logic [0:0] {
        KEY_IDLE = 1'b0,
        KEY_ARMED = 1'b1
    } wdrs_key_t;

endpackage : wdrs_pkg

`default_nettype wire

//--- rtl/wdrs_watchdog_reset.sv
/*
 * wdrs_watchdog_reset: software watchdog with write-once options and the
 * reset-cause recorder of the system control logic. it raises the system
 * reset and drives the cpu and pin defaults that stand during reset.
 * assumes: sys_rst_in is the power-on reset; cpu-side cause pulses and mode
 * levels come from logic on clk_sys_in; the pin reset, low-voltage and
 * clock-loss detectors and the 1 kHz source are asynchronous.
 */
// Behaviour
// - watchdog leaves every reset enabled, running with no software help.
// - writing 0x55 then 0xAA to the cause address restarts the timeout.
// - writes to the cause address change what it reads back only when they raise a watchdog reset.
// - counter reaching the selected timeout before service raises system reset.
// - any other byte written to the cause address resets at once.
// - clock select picks bus clock or the independent 1 kHz source.
// - three timeouts per clock source; timeout select zero disables the watchdog.
// - reset defaults are the 1 kHz source and 2^10 cycle timeout.
// - bus clock with window mode accepts service only in final 25%.
// - in window mode an early service write resets at once.
// - with the 1 kHz source window mode has no effect.
// - reset and first option writes restart counter; later option writes ignored.
// - bus clock: counter holds during debug halt or stop, then resumes.
// - 1 kHz source: counter cleared on debug halt or stop, restarts from zero.
// - eight reset causes are accepted, including debugger-forced reset.
// - every cause but debugger-forced sets its own bit in the cause register.
// - reset forces initial values and points fetch at vector 0xFFFE:0xFFFF.
// - reset disables peripherals and makes pins hi-z inputs without pullups.
// - reset sets the global interrupt mask and stack pointer 0x00FF.
`default_nettype none

module wdrs_watchdog_reset
    import wdrs_pkg::*;
#(
    parameter int LPO_EXP_SHORT = 5,
    parameter int LPO_EXP_MID = 8,
    parameter int LPO_EXP_LONG = 10,
    parameter int BUS_EXP_SHORT = 13,
    parameter int BUS_EXP_MID = 16,
    parameter int BUS_EXP_LONG = 18
) (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // reset sources
    input wire logic ext_reset_n_in,
    input wire logic low_voltage_reset_in,
    input wire logic clock_loss_reset_in,
    input wire logic illegal_opcode_reset_in,
    input wire logic illegal_address_reset_in,
    input wire logic debug_force_reset_in,
    // watchdog environment
    input wire logic lpo_clk_in,
    input wire logic debug_halt_in,
    input wire logic stop_mode_in,
    // system reset and reset-time defaults
    output logic sys_reset_out,
    output logic [15:0] reset_vector_addr_out,
    output logic [15:0] stack_pointer_init_out,
    output logic imask_set_out,
    output logic periph_disable_out,
    output logic pin_input_hiz_out,
    output logic pin_pullup_off_out
);

    // counter wide enough for the longest timeout of either clock
    localparam int CNT_W = (BUS_EXP_LONG > LPO_EXP_LONG ? BUS_EXP_LONG : LPO_EXP_LONG) + 1;
    localparam logic [HOLD_W-1:0] HOLD_CYC = HOLD_W'(RESET_HOLD_CYC);

    // ************************************************************
    // decoding functions
    // ************************************************************

    // timeout length in counter ticks for a clock choice and select value
    function automatic logic [CNT_W-1:0] tmo_limit(input logic use_lpo,
                                                  input logic [1:0] tmo);
        int unsigned e;
        e = 0;
        case (tmo)
            2'h1: e = use_lpo ? LPO_EXP_SHORT : BUS_EXP_SHORT;
            2'h2: e = use_lpo ? LPO_EXP_MID : BUS_EXP_MID;
            2'h3: e = use_lpo ? LPO_EXP_LONG : BUS_EXP_LONG;
            default: e = 0;
        endcase
        tmo_limit = CNT_W'(1) << e;
    endfunction : tmo_limit

    // register-port access hits a given offset
    function automatic logic hit(input logic strobe, input logic [ADDR_W-1:0] addr,
                                 input logic [ADDR_W-1:0] ofs);
        hit = strobe && (addr == ofs);
    endfunction : hit

    // ************************************************************
    // synchronisers for asynchronous inputs
    // ************************************************************
    // order: 3 = 1 kHz clock, 2 = pin reset asserted, 1 = low voltage, 0 = clock loss
    logic [3:0] async_raw;
    logic [3:0] sync_meta_reg;
    logic [3:0] sync_reg;
    logic [3:0] sync_prev_reg;
    logic [3:0] sync_rise;

    assign async_raw = {lpo_clk_in, ~ext_reset_n_in, low_voltage_reset_in,
                        clock_loss_reset_in};

    // two flops, then a third copy only for edge detection
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sync_meta_reg <= 4'h0;
            sync_reg <= 4'h0;
            sync_prev_reg <= 4'h0;
        end else begin
            sync_meta_reg <= async_raw;
            sync_reg <= sync_meta_reg;
            sync_prev_reg <= sync_reg;
        end
    end

    // a source held asserted causes one event, not a stream of them
    assign sync_rise = sync_reg & ~sync_prev_reg;

    // ************************************************************
    // reset event collection
    // ************************************************************
    logic [1:0] tmo_sel_reg;
    logic clksel_lpo_reg;
    logic window_en_reg;
    logic opt1_locked_reg;
    logic opt2_locked_reg;
    wdrs_key_t key_state_reg;
    logic [CNT_W-1:0] wdt_count_reg;
    logic [HOLD_W-1:0] hold_cnt_reg;
    logic rst_active_reg;

    logic wdt_enabled;
    logic low_power_mode;
    logic wdt_tick;
    logic [CNT_W-1:0] limit;
    logic win_open;
    logic blk_init;
    logic cause_wr;
    logic key_ok;
    logic bad_key;
    logic early_key;
    logic wdt_timeout;
    logic wdog_event;
    logic [7:0] cause_bits;
    logic sys_event;
    logic rst_active_next;

    assign wdt_enabled = (tmo_sel_reg != TMO_OFF);
    assign low_power_mode = debug_halt_in | stop_mode_in;
    assign limit = tmo_limit(clksel_lpo_reg, tmo_sel_reg);

    // bus clock ticks every cycle but freezes in debug or stop; 1 kHz ticks on its edge
    assign wdt_tick = clksel_lpo_reg ? sync_rise[3] : ~low_power_mode;

    // window only exists on the bus clock; the 1 kHz source ignores it
    assign win_open = clksel_lpo_reg || !window_en_reg ||
                      (wdt_count_reg >= (limit - (limit >> 2)));

    // block state is defaulted for the whole of any system reset
    assign blk_init = rst_active_reg;

    assign cause_wr = hit(reg_wr_in, reg_addr_in, OFS_CAUSE) && !blk_init;
    assign key_ok = (reg_wdata_in == KEY_FIRST) || (reg_wdata_in == KEY_SECOND);
    assign bad_key = cause_wr && !key_ok;
    assign early_key = cause_wr && key_ok && wdt_enabled && !win_open;

    // count reaches the limit on this tick
    assign wdt_timeout = !blk_init && wdt_enabled && wdt_tick &&
                         (wdt_count_reg == (limit - CNT_W'(1)));

    assign wdog_event = wdt_timeout | bad_key | early_key;

    // one bit per recorded cause; debugger-forced reset records none
    always_comb begin
        cause_bits = 8'h00;
        cause_bits[CAUSE_PIN] = sync_rise[2];
        cause_bits[CAUSE_LOWV] = sync_rise[1];
        cause_bits[CAUSE_CLKLOSS] = sync_rise[0];
        cause_bits[CAUSE_ILLEGAL_OPCODE_RESET] = illegal_opcode_reset_in;
        cause_bits[CAUSE_ILLEGAL_ADDRESS_RESET] = illegal_address_reset_in;
        cause_bits[CAUSE_WDOG] = wdog_event;
    end

    assign sys_event = (|cause_bits) | debug_force_reset_in;

    // ************************************************************
    // system reset hold
    // ************************************************************

    // reset stays active until the hold count runs out; a new event restarts it
    always_comb begin
        rst_active_next = 1'b0;
        if (sys_event) begin
            rst_active_next = 1'b1;
        end else if (hold_cnt_reg != '0) begin
            rst_active_next = (hold_cnt_reg != HOLD_W'(1));
        end
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            hold_cnt_reg <= HOLD_CYC;
            rst_active_reg <= 1'b1;
        end else begin
            if (sys_event) begin
                hold_cnt_reg <= HOLD_CYC;
            end else if (hold_cnt_reg != '0) begin
                hold_cnt_reg <= hold_cnt_reg - HOLD_W'(1);
            end
            rst_active_reg <= rst_active_next;
        end
    end

    // reset-time defaults for the cpu, peripherals and pins, all from flops
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sys_reset_out <= 1'b1;
            imask_set_out <= 1'b1;
            periph_disable_out <= 1'b1;
            pin_input_hiz_out <= 1'b1;
            pin_pullup_off_out <= 1'b1;
            reset_vector_addr_out <= RESET_VECTOR_ADDR;
            stack_pointer_init_out <= STACK_PTR_RST;
        end else begin
            sys_reset_out <= rst_active_next;
            imask_set_out <= rst_active_next;
            periph_disable_out <= rst_active_next;
            pin_input_hiz_out <= rst_active_next;
            pin_pullup_off_out <= rst_active_next;
            reset_vector_addr_out <= RESET_VECTOR_ADDR;
            stack_pointer_init_out <= STACK_PTR_RST;
        end
    end

    // ************************************************************
    // reset cause register
    // ************************************************************
    logic [7:0] cause_reg;

    // survives the block's own reset so software can see what happened;
    // power-on loads 0x80, each reset event overwrites it, and key writes touch it only when early in window mode
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cause_reg <= CAUSE_POR_VAL;
        end else if (sys_event) begin
            cause_reg <= cause_bits;
        end
    end

    // ************************************************************
    // write-once options
    // ************************************************************
    logic opt1_first_wr;
    logic opt2_first_wr;

    assign opt1_first_wr = hit(reg_wr_in, reg_addr_in, OFS_OPT1) && !blk_init &&
                           !opt1_locked_reg;
    assign opt2_first_wr = hit(reg_wr_in, reg_addr_in, OFS_OPT2) && !blk_init &&
                           !opt2_locked_reg;

    // defaults return on every system reset, so the watchdog always runs afterwards
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tmo_sel_reg <= TMO_RST;
            clksel_lpo_reg <= CLKSEL_RST;
            window_en_reg <= WINDOW_RST;
            opt1_locked_reg <= 1'b0;
            opt2_locked_reg <= 1'b0;
        end else if (blk_init) begin
            tmo_sel_reg <= TMO_RST;
            clksel_lpo_reg <= CLKSEL_RST;
            window_en_reg <= WINDOW_RST;
            opt1_locked_reg <= 1'b0;
            opt2_locked_reg <= 1'b0;
        end else begin
            // later writes find the lock set and fall through
            if (opt1_first_wr) begin
                tmo_sel_reg <= reg_wdata_in[OPT1_TMO_LSB +: 2];
                opt1_locked_reg <= 1'b1;
            end
            if (opt2_first_wr) begin
                clksel_lpo_reg <= reg_wdata_in[OPT2_CLKSEL_BIT];
                window_en_reg <= reg_wdata_in[OPT2_WINDOW_BIT];
                opt2_locked_reg <= 1'b1;
            end
        end
    end

    // ************************************************************
    // key sequence
    // ************************************************************
    logic service_done;

    // second key only counts when the first came before it
    assign service_done = cause_wr && (reg_wdata_in == KEY_SECOND) &&
                          (key_state_reg == KEY_ARMED) && !early_key;

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            key_state_reg <= KEY_IDLE;
        end else if (blk_init) begin
            key_state_reg <= KEY_IDLE;
        end else if (cause_wr) begin
            case (key_state_reg)
                KEY_IDLE: begin
                    if (reg_wdata_in == KEY_FIRST) begin
                        key_state_reg <= KEY_ARMED;
                    end
                end
                KEY_ARMED: begin
                    // a repeated first key keeps the sequence armed
                    if (reg_wdata_in != KEY_FIRST) begin
                        key_state_reg <= KEY_IDLE;
                    end
                end
                default: key_state_reg <= KEY_IDLE;
            endcase
        end
    end

    // ************************************************************
    // watchdog counter
    // ************************************************************

    // the 1 kHz count is wiped in debug or stop because that source keeps
    // running there; the bus-clock count simply stalls with wdt_tick low
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wdt_count_reg <= '0;
        end else if (blk_init || service_done || opt1_first_wr || opt2_first_wr) begin
            wdt_count_reg <= '0;
        end else if (clksel_lpo_reg && low_power_mode) begin
            wdt_count_reg <= '0;
        end else if (wdt_enabled && wdt_tick) begin
            wdt_count_reg <= wdt_count_reg + CNT_W'(1);
        end
    end

    // ************************************************************
    // read port
    // ************************************************************
    logic [7:0] rdata_next;

    always_comb begin
        rdata_next = 8'h00;
        case (reg_addr_in)
            OFS_CAUSE: rdata_next = cause_reg;
            OFS_OPT1: rdata_next[OPT1_TMO_LSB +: 2] = tmo_sel_reg;
            OFS_OPT2: begin
                rdata_next[OPT2_CLKSEL_BIT] = clksel_lpo_reg;
                rdata_next[OPT2_WINDOW_BIT] = window_en_reg;
            end
            OFS_STATUS: begin
                rdata_next[STAT_OPT1_LOCK] = opt1_locked_reg;
                rdata_next[STAT_OPT2_LOCK] = opt2_locked_reg;
                rdata_next[STAT_KEY_ARMED] = (key_state_reg == KEY_ARMED);
                rdata_next[STAT_WIN_OPEN] = win_open;
            end
            default: rdata_next = 8'h00;
        endcase
    end

    // data stands only in the cycle after the read strobe
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            reg_rdata_out <= rdata_next;
        end else begin
            reg_rdata_out <= 8'h00;
        end
    end

endmodule : wdrs_watchdog_reset

`default_nettype wire

//--- tb/wdrs_chk_sva.sv
/* wdrs_chk_sva: port checks of the watchdog and reset-source block.
   assumes one clock domain and the bind at the foot of this file. */
`default_nettype none
module wdrs_chk_sva
    import wdrs_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic illegal_opcode_reset_in,
    input wire logic debug_force_reset_in,
    input wire logic sys_reset_out,
    input wire logic [15:0] reset_vector_addr_out,
    input wire logic [15:0] stack_pointer_init_out,
    input wire logic imask_set_out,
    input wire logic pin_input_hiz_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (sys_rst_in);
    // ************************************************************
    // reset requests and reset-time outputs
    // ************************************************************
    sequence s_bad_key;
        reg_wr_in && reg_addr_in == OFS_CAUSE && !sys_reset_out
            && reg_wdata_in != KEY_FIRST && reg_wdata_in != KEY_SECOND;
    endsequence
    property p_bad_key;
        s_bad_key |=> sys_reset_out;
    endproperty
    a_bad_key: assert property (p_bad_key)
        else $error("non-key write gave no reset");
    property p_opcode;
        illegal_opcode_reset_in |=> sys_reset_out;
    endproperty
    a_opcode: assert property (p_opcode)
        else $error("illegal opcode gave no reset");
    property p_dbg;
        debug_force_reset_in |=> sys_reset_out;
    endproperty
    a_dbg: assert property (p_dbg)
        else $error("debugger reset not raised");
    // a reset that ends early leaves the core half-initialised
    property p_hold;
        $rose(sys_reset_out) |-> ##15 sys_reset_out;
    endproperty
    a_hold: assert property (p_hold)
        else $error("reset hold too short");
    property p_fell;
        $fell(sys_reset_out) |-> $past(sys_reset_out, 16);
    endproperty
    a_fell: assert property (p_fell)
        else $error("reset released too soon");
    property p_vec;
        sys_reset_out |-> reset_vector_addr_out == 16'hfffe;
    endproperty
    a_vec: assert property (p_vec)
        else $error("wrong reset vector address");
    property p_sp;
        sys_reset_out |-> stack_pointer_init_out == 16'h00ff && imask_set_out;
    endproperty
    a_sp: assert property (p_sp)
        else $error("stack pointer or mask wrong in reset");
    property p_pins;
        pin_input_hiz_out == sys_reset_out;
    endproperty
    a_pins: assert property (p_pins)
        else $error("pin default does not follow reset");
endmodule : wdrs_chk_sva

bind wdrs_watchdog_reset wdrs_chk_sva chk_u (
    .clk_sys_in,
    .sys_rst_in,
    .reg_addr_in,
    .reg_wdata_in,
    .reg_wr_in,
    .illegal_opcode_reset_in,
    .debug_force_reset_in,
    .sys_reset_out,
    .reset_vector_addr_out,
    .stack_pointer_init_out,
    .imask_set_out,
    .pin_input_hiz_out
);
`default_nettype wire

//--- tb/testbench.sv
/* testbench: drives the watchdog block at its ports, checks it against
   integer expectations. assumes bus timeouts shortened to 2^4/2^5/2^6. */
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module testbench;
    import wdrs_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] CAUSE_TAB [6] = '{8'h40, 8'h02, 8'h04, 8'h10, 8'h08, 8'h00};
    logic clk_sys_in, sys_rst_in, reg_wr_in, reg_rd_in, sys_reset_out, lpo;
    logic imask_set_out, periph_disable_out, pin_input_hiz_out, pin_pullup_off_out;
    logic [2:0] reg_addr_in;
    logic [7:0] reg_wdata_in, reg_rdata_out, rv;
    logic [15:0] reset_vector_addr_out, stack_pointer_init_out;
    logic [5:0] src; // pin, low v, clock loss, opcode, address, debugger
    logic [1:0] mode;
    int err_total, n_compared, n, lim;
    wdrs_watchdog_reset #(.BUS_EXP_SHORT(4), .BUS_EXP_MID(5), .BUS_EXP_LONG(6)) dut_u (
        .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .ext_reset_n_in(~src[0]),
        .low_voltage_reset_in(src[1]), .clock_loss_reset_in(src[2]),
        .illegal_opcode_reset_in(src[3]), .illegal_address_reset_in(src[4]),
        .debug_force_reset_in(src[5]), .lpo_clk_in(lpo), .debug_halt_in(mode[0]),
        .stop_mode_in(mode[1]), .sys_reset_out(sys_reset_out),
        .reset_vector_addr_out(reset_vector_addr_out),
        .stack_pointer_init_out(stack_pointer_init_out), .imask_set_out(imask_set_out),
        .periph_disable_out(periph_disable_out), .pin_input_hiz_out(pin_input_hiz_out),
        .pin_pullup_off_out(pin_pullup_off_out));
    // free-running 100 MHz clock
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    always #40 lpo = ~lpo; // 1 kHz source, sped up
    // ************************************************************
    // bus and wait tasks
    // ************************************************************
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim
    // strobe stays up between back-to-back writes
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_rd_in <= 1'b0;
        reg_wr_in <= 1'b1;
        @(posedge clk_sys_in);
    endtask : wr
    task automatic idle(input int k);
        reg_wr_in <= 1'b0;
        repeat (k) @(posedge clk_sys_in);
    endtask : idle
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        reg_addr_in <= a;
        reg_wr_in <= 1'b0;
        reg_rd_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        #1 d = reg_rdata_out;
    endtask : rd
    task automatic wait_rst(input logic lvl, input int lim_c, output int cnt);
        cnt = 0;
        #1;
        while (sys_reset_out !== lvl && cnt < lim_c) begin
            @(posedge clk_sys_in);
            #1 cnt++;
        end
        if (cnt >= lim_c) begin
            err_total++;
            end_sim();
        end
    endtask : wait_rst
    // both options are written so they lock; opt1 restarts the count
    task automatic cfg(input logic [7:0] o2, input logic [7:0] o1);
        wr(OFS_OPT2, o2);
        wr(OFS_OPT1, o1);
        idle(1);
    endtask : cfg
    task automatic bad_key();
        logic [7:0] b;
        do b = 8'($urandom); while (b == 8'h55 || b == 8'haa);
        wr(OFS_CAUSE, b);
        idle(1);
        `CHK(sys_reset_out, 1'b1)
        wait_rst(1'b0, 40, n);
        rd(OFS_CAUSE, rv);
        `CHK(rv, 8'h20)
    endtask : bad_key
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        {sys_rst_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = 14'h2000;
        {lpo, src, mode, err_total, n_compared} = '0;
        n = $urandom(32'h61579c1e);
        repeat (16) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        #1 `CHK(sys_reset_out, 1'b1)
        `CHK(stack_pointer_init_out, 16'h00ff)
        `CHK({periph_disable_out, pin_pullup_off_out}, 2'h3)
        wait_rst(1'b0, 40, n);
        rd(OFS_CAUSE, rv);
        `CHK(rv, 8'h80)
        rd(OFS_STATUS, rv);
        `CHK(rv[1:0], 2'h0)
        rd(3'h6, rv);
        `CHK(rv, 8'h00)
        // each source in turn, debugger last
        for (int i = 0; i < 6; i++) begin
            src <= 6'h01 << i;
            idle(4);
            src <= 6'h00;
            wait_rst(1'b1, 10, n);
            wait_rst(1'b0, 40, n);
            rd(OFS_CAUSE, rv);
            `CHK(rv, CAUSE_TAB[i])
        end
        bad_key();
        // bus clock timeouts for all three selections
        for (int t = 1; t < 4; t++) begin
            lim = 1 << (t + 3);
            cfg(8'h00, 8'(t));
            wait_rst(1'b1, 300, n);
            `CHK(n >= lim - 3 && n <= lim + 2, 1'b1)
            wait_rst(1'b0, 40, n);
        end
        cfg(8'h00, 8'h01);
        repeat (6) begin
            idle(6 + $urandom % 4);
            wr(OFS_CAUSE, KEY_FIRST);
            wr(OFS_CAUSE, KEY_SECOND);
        end
        idle(6);
        `CHK(sys_reset_out, 1'b0)
        rd(OFS_CAUSE, rv);
        `CHK(rv, 8'h20)
        wr(OFS_CAUSE, KEY_SECOND);
        idle(1);
        wait_rst(1'b1, 20, n);
        `CHK(n <= 10, 1'b1)
        wait_rst(1'b0, 40, n);
        // window: early key resets, late pair services
        cfg(8'h02, 8'h02);
        idle(3);
        wr(OFS_CAUSE, KEY_FIRST);
        idle(1);
        `CHK(sys_reset_out, 1'b1)
        wait_rst(1'b0, 40, n);
        cfg(8'h02, 8'h02);
        idle(24);
        wr(OFS_CAUSE, KEY_FIRST);
        wr(OFS_CAUSE, KEY_SECOND);
        idle(10);
        `CHK(sys_reset_out, 1'b0)
        bad_key();
        cfg(8'h03, 8'h01);
        wr(OFS_CAUSE, KEY_FIRST);
        wr(OFS_CAUSE, KEY_SECOND);
        idle(2);
        `CHK(sys_reset_out, 1'b0)
        idle(100);
        mode <= 2'h1;
        idle(100);
        mode <= 2'h0;
        wait_rst(1'b1, 400, n);
        `CHK(n > 240 && n < 264, 1'b1)
        wait_rst(1'b0, 40, n);
        bad_key();
        cfg(8'h00, 8'h00);
        cfg(8'h00, 8'h01);
        idle(200);
        `CHK(sys_reset_out, 1'b0)
        rd(OFS_STATUS, rv);
        `CHK(rv[1:0], 2'h3)
        // halt and stop freeze a bus-clock count without clearing it
        for (int m = 1; m < 3; m++) begin
            bad_key();
            cfg(8'h00, 8'h01);
            idle(4);
            mode <= 2'(m);
            idle(60);
            `CHK(sys_reset_out, 1'b0)
            mode <= 2'h0;
            wait_rst(1'b1, 20, n);
            `CHK(n >= 6 && n <= 14, 1'b1)
            wait_rst(1'b0, 40, n);
        end
        end_sim();
    end
endmodule : testbench
`default_nettype wire
